// *** cxe_pkg.sv ***
package cxe_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_INSTR  = 8'h04;
    localparam logic [7:0] OFF_OPND   = 8'h08;
    localparam logic [7:0] OFF_WORK   = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_BANK   = 8'h14;
    localparam logic [7:0] OFF_PTR0   = 8'h18;
    localparam logic [7:0] OFF_PTR1   = 8'h1C;
    localparam logic [7:0] OFF_PTR2   = 8'h20;
    localparam logic [7:0] OFF_PC     = 8'h24;
    localparam logic [7:0] OFF_STACK  = 8'h28;
    localparam logic [7:0] OFF_LATCH  = 8'h2C;
    localparam logic [7:0] OFF_CYCLES = 8'h30;
    localparam logic [7:0] OFF_FADDR  = 8'h34;
    localparam logic [7:0] OFF_FDATA  = 8'h38;
    // status and control field positions
    localparam int ST_BUSY  = 0;
    localparam int ST_SKIP  = 1;
    localparam int ST_NEG   = 2;
    localparam int ST_ZERO  = 3;
    localparam int ST_UNSUP = 4;
    localparam int CTRL_EXT = 0;
    // opcode patterns
    localparam logic [6:0]  OP_TEST_SKIP = 7'h33;
    localparam logic [7:0]  OP_XOR_LIT   = 8'h0A;
    localparam logic [5:0]  OP_XOR_FILE  = 6'h06;
    localparam logic [15:0] OP_CALL_WORK = 16'h0014;
    localparam logic [3:0]  OP_EXT    = 4'hE;
    localparam logic [3:0]  EXT_ADD   = 4'h8;
    localparam logic [3:0]  EXT_SUB   = 4'h9;
    localparam logic [3:0]  EXT_PUSH  = 4'hA;
    localparam logic [3:0]  EXT_MOVS  = 4'hB;
    localparam logic [3:0]  OP_FILE_MOVE = 4'hC;
    localparam logic [3:0]  OP_WORD2  = 4'hF;
    localparam logic [1:0]  SEL_RET   = 2'h3;
    localparam logic [7:0]  ACC_SPLIT = 8'h5F;
    localparam logic [3:0]  ACC_HIGH  = 4'hF;
    // timing: four phases per instruction cycle
    localparam logic [1:0]  Q_LAST    = 2'h3;
    localparam logic [20:0] PC_STEP1  = 21'h000002;
    localparam logic [20:0] PC_STEP2  = 21'h000004;

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_EXTRA} cxe_state_type;

    typedef struct packed {
        cxe_state_type    state;
        logic [1:0]       q;
        logic [1:0]       extra;
        logic             skip;
        logic             ext_en;
        logic             unsup;
        logic             n;
        logic             z;
        logic [7:0]       w;
        logic [3:0]       bank;
        logic [2:0][11:0] ptr;
        logic [20:0]      pc;
        logic [20:0]      stack_top;
        logic [7:0]       plh;
        logic [4:0]       plu;
        logic [15:0]      ir1;
        logic [15:0]      ir2;
        logic [11:0]      faddr;
        logic [15:0]      cycles;
        logic [31:0]      rdata;
    } cxe_st_type;

    localparam cxe_st_type ST_RESET = '0;
endpackage

// *** cxe_addr_resolve.sv ***
`timescale 1ns/1ps
module cxe_addr_resolve
(
    // operand fields
    input  wire logic        a_bit,
    input  wire logic [7:0]  f,
    // context
    input  wire logic [3:0]  bank,
    input  wire logic        ext_en,
    input  wire logic [11:0] ptr2,
    // resolved address
    output logic [11:0]      addr
);
    import cxe_pkg::*;

    // bank, indexed or access-bank decode
    always_comb
    begin
        if (a_bit)
            addr = {bank, f};
        else if (ext_en && f <= ACC_SPLIT)
            addr = 12'(ptr2 + {4'h0, f});
        else if (f <= ACC_SPLIT)
            addr = {4'h0, f};
        else
            addr = {ACC_HIGH, f};
    end
endmodule

// *** cxe_ptr_adj.sv ***
`timescale 1ns/1ps
module cxe_ptr_adj
(
    // pointer and literal
    input  wire logic [11:0] ptr,
    input  wire logic [7:0]  k,
    input  wire logic        sub,
    // adjusted pointer
    output logic [11:0]      res
);
    // unsigned add or subtract, wraps at 12 bits
    assign res = sub ? 12'(ptr - {4'h0, k}) : 12'(ptr + {4'h0, k});
endmodule

// *** cxe_core.sv ***
`timescale 1ns/1ps
module cxe_core
#(
    parameter int MEM_AW = 12
)
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // state
    output logic             BUSY
);
    import cxe_pkg::*;

    if (MEM_AW != 12)
        $error("cxe_core: MEM_AW must be 12");

    cxe_st_type  st_r;
    cxe_st_type  st_nxt;
    logic [7:0]  mem [0:(1<<MEM_AW)-1];
    logic        mem_we;
    logic [11:0] mem_wa;
    logic [7:0]  mem_wd;
    logic [11:0] addr_f;
    logic [7:0]  fval;
    logic [7:0]  xor_res;
    logic [11:0] ptr_in;
    logic [7:0]  ptr_k;
    logic        ptr_sub;
    logic [11:0] ptr_res;
    logic [11:0] src_idx;
    logic [11:0] dst_idx;
    logic [20:0] pc_plus2;
    logic        exec_done;
    logic        two_word;
    logic        is_ext;
    logic        wr_fire;
    logic        mapped;
    logic [1:0]  sel;

    // operand address and pointer arithmetic
    cxe_addr_resolve u_addr
    (
        .a_bit  (st_r.ir1[8]),
        .f      (st_r.ir1[7:0]),
        .bank   (st_r.bank),
        .ext_en (st_r.ext_en),
        .ptr2   (st_r.ptr[2]),
        .addr   (addr_f)
    );

    cxe_ptr_adj u_ptr
    (
        .ptr (ptr_in),
        .k   (ptr_k),
        .sub (ptr_sub),
        .res (ptr_res)
    );

    // decode helpers
    assign sel       = st_r.ir1[7:6];
    assign fval      = mem[addr_f];
    assign xor_res   = st_r.w ^ fval;
    assign src_idx   = 12'(st_r.ptr[2] + {5'h00, st_r.ir1[6:0]});
    assign dst_idx   = 12'(st_r.ptr[2] + {5'h00, st_r.ir2[6:0]});
    assign pc_plus2  = 21'(st_r.pc + PC_STEP1);
    assign exec_done = (st_r.state == S_EXEC) && (st_r.q == Q_LAST);
    assign is_ext    = (st_r.ir1[15:12] == OP_EXT && st_r.ir1[11:10] == 2'b10)
                     || (st_r.ir1 == OP_CALL_WORK);
    assign two_word  = (st_r.ir1[15:12] == OP_FILE_MOVE)
                     || (st_r.ir1[15:12] == OP_EXT && st_r.ir1[11:10] == 2'b11)
                     || (st_r.ext_en && st_r.ir1[15:8] == {OP_EXT, EXT_MOVS});

    // pointer unit operand select
    always_comb
    begin
        ptr_in  = st_r.ptr[2];
        ptr_k   = {2'b00, st_r.ir1[5:0]};
        ptr_sub = st_r.ir1[8];
        if (st_r.ir1[11:8] == EXT_PUSH)
        begin
            ptr_k   = 8'h01;
            ptr_sub = 1'b1;
        end
        else if (sel != SEL_RET)
            ptr_in = st_r.ptr[sel];
    end

    // apb decode and handshake
    assign mapped  = (PADDR[1:0] == 2'b00) && (PADDR <= OFF_FDATA);
    assign PREADY  = PWRITE ? (st_r.state == S_IDLE) : 1'b1;
    assign PSLVERR = PSEL && PENABLE && PREADY && !mapped;
    assign wr_fire = PSEL && PENABLE && PWRITE && PREADY && mapped;
    assign PRDATA  = st_r.rdata;
    assign BUSY    = (st_r.state != S_IDLE);

    // next state
    always_comb
    begin
        st_nxt = st_r;
        mem_we = 1'b0;
        mem_wa = addr_f;
        mem_wd = xor_res;
        // read data captured in the setup phase
        if (PSEL && !PENABLE && !PWRITE)
        begin
            unique case (PADDR)
                OFF_CTRL:   st_nxt.rdata = {31'h0, st_r.ext_en};
                OFF_INSTR:  st_nxt.rdata = {16'h0, st_r.ir1};
                OFF_OPND:   st_nxt.rdata = {16'h0, st_r.ir2};
                OFF_WORK:   st_nxt.rdata = {24'h0, st_r.w};
                OFF_STATUS: st_nxt.rdata = {27'h0, st_r.unsup, st_r.z, st_r.n,
                                            st_r.skip, BUSY};
                OFF_BANK:   st_nxt.rdata = {28'h0, st_r.bank};
                OFF_PTR0:   st_nxt.rdata = {20'h0, st_r.ptr[0]};
                OFF_PTR1:   st_nxt.rdata = {20'h0, st_r.ptr[1]};
                OFF_PTR2:   st_nxt.rdata = {20'h0, st_r.ptr[2]};
                OFF_PC:     st_nxt.rdata = {11'h0, st_r.pc};
                OFF_STACK:  st_nxt.rdata = {11'h0, st_r.stack_top};
                OFF_LATCH:  st_nxt.rdata = {19'h0, st_r.plu, st_r.plh};
                OFF_CYCLES: st_nxt.rdata = {16'h0, st_r.cycles};
                OFF_FADDR:  st_nxt.rdata = {20'h0, st_r.faddr};
                OFF_FDATA:  st_nxt.rdata = {24'h0, mem[st_r.faddr]};
                default:    st_nxt.rdata = 32'h0;
            endcase
        end
        // register writes, only taken while idle
        if (wr_fire)
        begin
            unique case (PADDR)
                OFF_CTRL:   st_nxt.ext_en = PWDATA[CTRL_EXT];
                OFF_INSTR:
                begin
                    st_nxt.ir1   = PWDATA[15:0];
                    st_nxt.state = S_EXEC;
                    st_nxt.q     = 2'h0;
                end
                OFF_OPND:   st_nxt.ir2 = PWDATA[15:0];
                OFF_WORK:   st_nxt.w = PWDATA[7:0];
                OFF_STATUS:
                begin
                    if (PWDATA[ST_UNSUP])
                        st_nxt.unsup = 1'b0;
                    if (PWDATA[ST_SKIP])
                        st_nxt.skip = 1'b0;
                end
                OFF_BANK:   st_nxt.bank = PWDATA[3:0];
                OFF_PTR0:   st_nxt.ptr[0] = PWDATA[11:0];
                OFF_PTR1:   st_nxt.ptr[1] = PWDATA[11:0];
                OFF_PTR2:   st_nxt.ptr[2] = PWDATA[11:0];
                OFF_PC:     st_nxt.pc = PWDATA[20:0];
                OFF_STACK:  st_nxt.stack_top = PWDATA[20:0];
                OFF_LATCH:
                begin
                    st_nxt.plh = PWDATA[7:0];
                    st_nxt.plu = PWDATA[12:8];
                end
                OFF_CYCLES: st_nxt.cycles = PWDATA[15:0];
                OFF_FADDR:  st_nxt.faddr = PWDATA[11:0];
                OFF_FDATA:
                begin
                    mem_we = 1'b1;
                    mem_wa = st_r.faddr;
                    mem_wd = PWDATA[7:0];
                end
                default:    st_nxt.cycles = st_r.cycles;
            endcase
        end
        // phase counter and instruction cycle count
        if (st_r.state != S_IDLE)
        begin
            st_nxt.q = 2'(st_r.q + 2'h1);
            if (st_r.q == Q_LAST)
                st_nxt.cycles = 16'(st_r.cycles + 16'h1);
        end
        // trailing no-operation cycles
        if (st_r.state == S_EXTRA && st_r.q == Q_LAST)
        begin
            st_nxt.extra = 2'(st_r.extra - 2'h1);
            if (st_r.extra == 2'h1)
                st_nxt.state = S_IDLE;
        end
        // execute at the last phase of the first cycle
        if (exec_done)
        begin
            st_nxt.extra = 2'h0;
            st_nxt.pc    = pc_plus2;
            if (st_r.skip)
            begin
                st_nxt.skip = 1'b0;
                if (two_word)
                begin
                    st_nxt.extra = 2'h1;
                    st_nxt.pc    = 21'(st_r.pc + PC_STEP2);
                end
            end
            else if (st_r.ir1[15:9] == OP_TEST_SKIP)
                st_nxt.skip = (fval == 8'h00);
            else if (st_r.ir1[15:8] == OP_XOR_LIT)
            begin
                st_nxt.w = st_r.w ^ st_r.ir1[7:0];
                st_nxt.n = st_nxt.w[7];
                st_nxt.z = (st_nxt.w == 8'h00);
            end
            else if (st_r.ir1[15:10] == OP_XOR_FILE)
            begin
                st_nxt.n = xor_res[7];
                st_nxt.z = (xor_res == 8'h00);
                if (st_r.ir1[9])
                    mem_we = 1'b1;
                else
                    st_nxt.w = xor_res;
            end
            else if (is_ext && !st_r.ext_en)
                st_nxt.unsup = 1'b1;
            else if (st_r.ir1 == OP_CALL_WORK)
            begin
                st_nxt.stack_top = pc_plus2;
                st_nxt.pc    = {st_r.plu, st_r.plh, st_r.w};
                st_nxt.extra = 2'h1;
            end
            else if (st_r.ir1[15:12] == OP_EXT)
            begin
                unique case (st_r.ir1[11:8])
                    EXT_ADD, EXT_SUB:
                    begin
                        if (sel == SEL_RET)
                        begin
                            st_nxt.ptr[2] = ptr_res;
                            st_nxt.pc     = st_r.stack_top;
                            st_nxt.extra  = 2'h1;
                        end
                        else
                            st_nxt.ptr[sel] = ptr_res;
                    end
                    EXT_PUSH:
                    begin
                        mem_we        = 1'b1;
                        mem_wa        = st_r.ptr[2];
                        mem_wd        = st_r.ir1[7:0];
                        st_nxt.ptr[2] = ptr_res;
                    end
                    EXT_MOVS:
                    begin
                        st_nxt.pc = 21'(st_r.pc + PC_STEP2);
                        if (st_r.ir2[15:12] == OP_WORD2)
                        begin
                            mem_we       = 1'b1;
                            mem_wa       = st_r.ir1[7] ? dst_idx : st_r.ir2[11:0];
                            mem_wd       = mem[src_idx];
                            st_nxt.extra = 2'h1;
                        end
                        else
                            st_nxt.unsup = 1'b1;
                    end
                    default: st_nxt.unsup = 1'b1;
                endcase
            end
            else
                st_nxt.unsup = 1'b1;
            st_nxt.state = (st_nxt.extra == 2'h0) ? S_IDLE : S_EXTRA;
        end
    end

    // state register
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            st_r <= ST_RESET;
        else
            st_r <= st_nxt;
    end

    // file register memory
    always_ff @(posedge CLK)
    begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    AST_SKIP_NOP: assert property (exec_done && st_r.skip && !two_word |=>
        st_r.state == S_IDLE && st_r.w == $past(st_r.w) && !st_r.skip)
        else $error("skipped instruction not replaced by a no-operation");
    AST_SKIP_TWO: assert property (exec_done && st_r.skip && two_word |=>
        (st_r.state == S_EXTRA) [*4] ##1 st_r.state == S_IDLE)
        else $error("skipped two-word instruction did not take two cycles");
    AST_BANK: assert property (st_r.ir1[8] |-> addr_f == {st_r.bank, st_r.ir1[7:0]})
        else $error("bank select address wrong");
    AST_INDEXED: assert property (st_r.ext_en && !st_r.ir1[8]
        && st_r.ir1[7:0] <= ACC_SPLIT |-> addr_f == 12'(st_r.ptr[2] + st_r.ir1[7:0]))
        else $error("indexed literal offset address wrong");
    AST_XOR_LIT: assert property (exec_done && !st_r.skip
        && st_r.ir1[15:8] == OP_XOR_LIT |=> st_r.w == ($past(st_r.w) ^ $past(st_r.ir1[7:0]))
        && st_r.z == (st_r.w == 8'h00) && st_r.state == S_IDLE)
        else $error("literal xor result wrong");
    AST_XOR_FILE_W: assert property (exec_done && !st_r.skip
        && st_r.ir1[15:10] == OP_XOR_FILE && !st_r.ir1[9] |=> st_r.w == $past(xor_res))
        else $error("file xor to work register wrong");
    AST_RETURN: assert property (exec_done && !st_r.skip && st_r.ext_en
        && st_r.ir1[15:12] == OP_EXT && st_r.ir1[11:9] == 3'b100 && sel == SEL_RET
        |=> st_r.pc == $past(st_r.stack_top) && st_r.ptr[2] == $past(ptr_res)
        ##4 st_r.state == S_IDLE)
        else $error("returning pointer adjust wrong");
    AST_CALL_WORK: assert property (exec_done && !st_r.skip && st_r.ext_en
        && st_r.ir1 == OP_CALL_WORK |=> st_r.stack_top == $past(pc_plus2)
        && st_r.pc[7:0] == $past(st_r.w) && st_r.state == S_EXTRA)
        else $error("call via work register wrong");
    AST_PUSH: assert property (exec_done && !st_r.skip && st_r.ext_en
        && st_r.ir1[15:8] == {OP_EXT, EXT_PUSH}
        |=> st_r.ptr[2] == 12'($past(st_r.ptr[2]) - 12'h001) && st_r.state == S_IDLE)
        else $error("literal push pointer not decremented");
    AST_EXT_OFF: assert property (exec_done && !st_r.skip && !st_r.ext_en
        && is_ext |=> st_r.ptr == $past(st_r.ptr) && st_r.unsup && st_r.state == S_IDLE)
        else $error("extended opcode executed while disabled");

    COV_SKIP: cover property (exec_done && st_r.skip && two_word);
    COV_CALL_WORK: cover property (exec_done && st_r.ext_en && st_r.ir1 == OP_CALL_WORK);
    COV_RET: cover property (exec_done && st_r.ext_en && is_ext && sel == SEL_RET);
    COV_IDX_MOVE: cover property (exec_done && mem_we && st_r.ir1[15:8] == {OP_EXT, EXT_MOVS});
endmodule

// *** cpu_xor_skip_and_ext_opcodes_bench.sv ***
`timescale 1ns/1ps
module cpu_xor_skip_and_ext_opcodes_bench;
    import cxe_pkg::*;

    // clock, reset and bus drive
    logic        clk         = 1'b0;
    logic        reset_n     = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic [31:0] rd;
    logic [31:0] c0;
    logic        err;
    int          err_count   = 0;
    int          checks_done = 0;
    int          ticks       = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    cxe_core #(.MEM_AW(12)) uut
    (
        .CLK     (clk),
        .RESET_N (reset_n),
        .PSEL    (psel),
        .PENABLE (penable),
        .PWRITE  (pwrite),
        .PADDR   (paddr),
        .PWDATA  (pwdata),
        .PRDATA  (prdata),
        .PREADY  (pready),
        .PSLVERR (pslverr),
        .BUSY    (busy)
    );

    // compare and count
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; pready, read data and error are taken at the rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    // issue one instruction and wait for the core to go idle
    task automatic exec(input logic [15:0] ins);
        wr(OFF_INSTR, {16'h0, ins});
        @(negedge clk);
        while (busy !== 1'b0)
            @(negedge clk);
    endtask

    // issue one instruction and check the instruction cycles it cost
    task automatic run(input logic [15:0] ins, input logic [31:0] cyc);
        apb(1'b0, OFF_CYCLES, 32'h0);
        c0 = rd;
        exec(ins);
        rchk(OFF_CYCLES, c0 + cyc, "cycles");
    endtask

    task automatic close_out();
        $display("TB: checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        ticks <= ticks + 1;
        if (ticks == 20000)
        begin
            err_count++;
            close_out();
        end
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rchk(OFF_CTRL, 32'h0, "ctrl");
        rchk(OFF_STATUS, 32'h0, "status");
        apb(1'b0, 8'h3C, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        // literal xor: plain, zero and negative results
        wr(OFF_WORK, 32'hB5);
        run(16'h0AAF, 32'h1);
        rchk(OFF_WORK, 32'h1A, "w");
        rchk(OFF_STATUS, 32'h0, "flags");
        run(16'h0A1A, 32'h1);
        rchk(OFF_STATUS, 32'h08, "zero");
        run(16'h0A80, 32'h1);
        rchk(OFF_STATUS, 32'h04, "neg");
        // a write issued while busy waits until the instruction is done
        wr(OFF_INSTR, 32'h0AFF);
        wr(OFF_WORK, 32'h33);
        rchk(OFF_WORK, 32'h33, "w after wait");
        wr(OFF_INSTR, 32'h0A00);
        rchk(OFF_STATUS, 32'h01, "busy");
        // file xor through the bank register, then the access bank
        wr(OFF_BANK, 32'h2);
        wr(OFF_FADDR, 32'h2AA);
        wr(OFF_FDATA, 32'hAF);
        wr(OFF_WORK, 32'hB5);
        run(16'h1BAA, 32'h1);
        rchk(OFF_FDATA, 32'h1A, "file");
        rchk(OFF_WORK, 32'hB5, "w kept");
        wr(OFF_FADDR, 32'hFAA);
        wr(OFF_FDATA, 32'h0F);
        run(16'h18AA, 32'h1);
        rchk(OFF_WORK, 32'hBA, "w");
        rchk(OFF_STATUS, 32'h04, "neg");
        rchk(OFF_FDATA, 32'h0F, "file kept");
        // test and skip: one-word victim, two-word victim, no skip
        wr(OFF_FADDR, 32'h240);
        wr(OFF_FDATA, 32'h0);
        wr(OFF_PC, 32'h0);
        run(16'h6740, 32'h1);
        rchk(OFF_STATUS, 32'h06, "skip");
        run(16'h0A55, 32'h1);
        rchk(OFF_WORK, 32'hBA, "w skipped");
        run(16'h6740, 32'h1);
        run(16'hC123, 32'h2);
        rchk(OFF_PC, 32'h0A, "pc");
        wr(OFF_FDATA, 32'h1);
        run(16'h6740, 32'h1);
        rchk(OFF_STATUS, 32'h04, "no skip");
        rchk(OFF_PC, 32'h0C, "pc");
        // extended set on: indexed literal offset
        wr(OFF_CTRL, 32'h1);
        wr(OFF_PTR2, 32'h100);
        wr(OFF_FADDR, 32'h110);
        wr(OFF_FDATA, 32'h55);
        wr(OFF_WORK, 32'h55);
        run(16'h1810, 32'h1);
        rchk(OFF_WORK, 32'h0, "indexed");
        // pointer add and subtract
        wr(OFF_PTR1, 32'h3FF);
        wr(OFF_PTR0, 32'h100);
        run(16'hE863, 32'h1);
        rchk(OFF_PTR1, 32'h422, "add");
        run(16'hE93F, 32'h1);
        rchk(OFF_PTR0, 32'hC1, "sub");
        rchk(OFF_STATUS, 32'h08, "flags kept");
        // returning variants
        wr(OFF_PTR2, 32'h3FF);
        wr(OFF_STACK, 32'h200);
        wr(OFF_PC, 32'h100);
        run(16'hE8E3, 32'h2);
        rchk(OFF_PTR2, 32'h422, "ptr2");
        rchk(OFF_PC, 32'h200, "pc");
        run(16'hE9C2, 32'h2);
        rchk(OFF_PTR2, 32'h420, "ptr2");
        // literal push then indexed moves
        run(16'hEA5A, 32'h1);
        rchk(OFF_PTR2, 32'h41F, "ptr2");
        wr(OFF_FADDR, 32'h420);
        rchk(OFF_FDATA, 32'h5A, "pushed");
        wr(OFF_OPND, 32'hF123);
        run(16'hEB01, 32'h2);
        wr(OFF_FADDR, 32'h123);
        rchk(OFF_FDATA, 32'h5A, "move f");
        wr(OFF_OPND, 32'hF003);
        run(16'hEB81, 32'h2);
        wr(OFF_FADDR, 32'h422);
        rchk(OFF_FDATA, 32'h5A, "move s");
        // call through the work register
        wr(OFF_PC, 32'h100);
        wr(OFF_WORK, 32'h06);
        wr(OFF_LATCH, 32'h10);
        run(16'h0014, 32'h2);
        rchk(OFF_PC, 32'h1006, "pc");
        rchk(OFF_STACK, 32'h102, "stack");
        rchk(OFF_STATUS, 32'h08, "status");
        // extended set off again: pointer add is refused
        wr(OFF_CTRL, 32'h0);
        exec(16'hE863);
        rchk(OFF_PTR1, 32'h422, "ptr1");
        rchk(OFF_STATUS, 32'h18, "unsup");
        close_out();
    end
endmodule
